/* File: verilog/lah_listener_holdoff.sv */
// Listener receive path with RFD and DAC acceptor holdoffs.
// Assumes all inputs are synchronous to ref_clk and that the bus handshake
// logic presents each accepted byte as a one-cycle pulse.
`timescale 1ns/1ps
`include "lah_cfg.svh"
module lah_listener_holdoff (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Bus side: accepted byte strobe, ATN, EOI, addressing
	input wire logic byte_accepted,
	input wire logic [7:0] bus_data,
	input wire logic bus_eoi,
	input wire logic bus_atn,
	input wire logic listener_addressed,
	input wire logic talker_addressed,
	input wire logic talker_primary_seen,
	input wire logic listener_primary_seen,
	input wire logic cmd_undefined,
	// Host side: auxiliary command strobe and receive register read
	input wire lah_pkg::lah_aux_t aux_cmd,
	input wire logic aux_cmd_strobe,
	input wire logic rx_read_strobe,
	// Configuration
	input wire logic [1:0] aux_mode_reg_a,
	input wire logic [7:0] match_char_reg,
	input wire logic match_end_enable,
	input wire logic newline_end_enable,
	input wire logic newline_term_enable,
	input wire logic data_in_irq_enable,
	input wire logic dma_input_enable,
	input wire logic dual_ext_addr,
	// DAC hold selections
	input wire logic passthrough_enable,
	input wire logic secondary_passthrough_opt,
	input wire logic hold_on_trigger_cmd,
	input wire logic hold_on_trigger_state,
	input wire logic hold_on_clear_cmd,
	input wire logic hold_on_clear_state,
	input wire logic hold_on_talk_group,
	input wire logic hold_on_listen_group,
	input wire logic hold_on_unaddress,
	input wire logic hold_every_command,
	// DMA
	input wire logic dma_ack_pin,
	output logic dma_request_pin,
	// Receive data and status
	output logic [7:0] rx_data,
	output logic data_in_flag,
	output logic data_in_irq,
	output logic end_rx_flag,
	output logic eoi_seen,
	output logic newline_hit_flag,
	output logic match_char_hit_flag,
	output logic [7:0] irq_status_1,
	output logic [7:0] acceptor_status_reg,
	// Handshake controls
	output logic nrfd_assert,
	output logic dac_holdoff,
	output logic ready_for_next,
	output logic monitor_mode_active
);
	import lah_pkg::*;

	// ----------------------------------------
	// State record
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] rx_byte;
		logic data_in;
		logic end_rx;
		logic eoi_seen;
		logic nl_hit;
		logic match_hit;
		logic imm_hold;
		logic data_hold;
		logic hold_needs_release;
		logic accept_hold_state;
		logic cont_forced;
		logic dma_req;
		logic nrfd;
		logic rdy;
		logic irq;
	} lah_state_t;

	lah_state_t st_ff;
	lah_state_t nxt_st;

	logic newline_hit;
	logic match_hit;
	logic end_hit;
	logic end_cond;
	logic select_hold_signal;
	lah_mode_t mode;
	logic data_byte;
	logic cmd_byte;
	logic rx_read;
	logic release_cmd;
	logic rdy_now;

	// ----------------------------------------
	// Byte classifiers
	// ----------------------------------------
	lah_end_detect u_end (
		.rx_byte(bus_data),
		.rx_eoi(bus_eoi),
		.match_char_reg(match_char_reg),
		.match_end_enable(match_end_enable),
		.newline_end_enable(newline_end_enable),
		.newline_term_enable(newline_term_enable),
		.newline_hit(newline_hit),
		.match_hit(match_hit),
		.end_hit(end_hit),
		.end_cond(end_cond)
	);

	lah_cmd_decode u_cmd (
		.cmd_byte(bus_data),
		.talker_addressed(talker_addressed),
		.listener_addressed(listener_addressed),
		.talker_primary_seen(talker_primary_seen),
		.listener_primary_seen(listener_primary_seen),
		.dual_ext_addr(dual_ext_addr),
		.cmd_undefined(cmd_undefined),
		.passthrough_enable(passthrough_enable),
		.secondary_passthrough_opt(secondary_passthrough_opt),
		.hold_on_trigger_cmd(hold_on_trigger_cmd),
		.hold_on_trigger_state(hold_on_trigger_state),
		.hold_on_clear_cmd(hold_on_clear_cmd),
		.hold_on_clear_state(hold_on_clear_state),
		.hold_on_talk_group(hold_on_talk_group),
		.hold_on_listen_group(hold_on_listen_group),
		.hold_on_unaddress(hold_on_unaddress),
		.hold_every_command(hold_every_command),
		.select_hold_signal(select_hold_signal)
	);

	// ----------------------------------------
	// Mode selection and event decode
	// ----------------------------------------
	// Forced monitor mode overrides the field; the field decodes to one of four modes
	always_comb begin
		if (st_ff.cont_forced) begin
			mode = LAH_CONT;
		end else begin
			unique case (aux_mode_reg_a)
				`LAH_MODE_HOLD_ALL: mode = LAH_HOLD_ALL;
				`LAH_MODE_HOLD_END: mode = LAH_HOLD_END;
				`LAH_MODE_CONT: mode = LAH_CONT;
				default: mode = LAH_NORMAL;
			endcase
		end
		data_byte = byte_accepted & ~bus_atn & listener_addressed;
		cmd_byte = byte_accepted & bus_atn;
		// A DMA acknowledge counts as a read of the receive register
		rx_read = rx_read_strobe | (dma_ack_pin & st_ff.dma_req);
		release_cmd = aux_cmd_strobe & (aux_cmd == `LAH_AUX_RHDF);
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// Reading the register empties it; a new byte in the same cycle wins below
		if (rx_read) begin
			nxt_st.data_in = 1'b0;
		end
		// Soft holdoff released by a read
		if (rx_read && st_ff.data_hold && !st_ff.hold_needs_release) begin
			nxt_st.data_hold = 1'b0;
		end
		// Release command clears any RFD holdoff
		if (release_cmd) begin
			nxt_st.imm_hold = 1'b0;
			nxt_st.data_hold = 1'b0;
			nxt_st.hold_needs_release = 1'b0;
		end

		// Data byte acceptance per receiving mode
		if (data_byte) begin
			nxt_st.end_rx = st_ff.end_rx | end_hit;
			nxt_st.eoi_seen = bus_eoi;
			nxt_st.nl_hit = newline_hit;
			nxt_st.match_hit = match_hit;
			unique case (mode)
				LAH_NORMAL: begin
					nxt_st.data_hold = 1'b1;
					nxt_st.hold_needs_release = 1'b0;
				end
				LAH_HOLD_ALL: begin
					nxt_st.data_hold = 1'b1;
					nxt_st.hold_needs_release = 1'b1;
				end
				LAH_HOLD_END: begin
					nxt_st.data_hold = 1'b1;
					nxt_st.hold_needs_release = end_cond;
				end
				LAH_CONT: begin
					nxt_st.data_hold = end_cond;
					nxt_st.hold_needs_release = end_cond;
				end
			endcase
			if (mode != LAH_CONT) begin
				nxt_st.rx_byte = bus_data;
				nxt_st.data_in = 1'b1;
			end
		end
		if (rx_read && !data_byte) begin
			nxt_st.end_rx = 1'b0;
		end

		// DAC holdoff on selected command bytes; valid or nonvalid releases it
		if (aux_cmd_strobe && (aux_cmd == `LAH_AUX_VALID || aux_cmd == `LAH_AUX_NONVALID)) begin
			nxt_st.accept_hold_state = 1'b0;
		end
		if (cmd_byte && select_hold_signal) begin
			nxt_st.accept_hold_state = 1'b1;
		end

		// Other auxiliary commands
		if (aux_cmd_strobe) begin
			unique case (aux_cmd)
				`LAH_AUX_HLDI: nxt_st.imm_hold = 1'b1;
				`LAH_AUX_LTN_CONT: nxt_st.cont_forced = 1'b1;
				`LAH_AUX_LTN: nxt_st.cont_forced = 1'b0;
				`LAH_AUX_CHIP_RESET: begin
					nxt_st = '0;
					nxt_st.rdy = 1'b1;
				end
				default: begin
				end
			endcase
		end
		// Losing listener address ends forced monitoring
		if (!listener_addressed) begin
			nxt_st.cont_forced = 1'b0;
		end

		// Ready message and handshake outputs
		rdy_now = bus_atn | (!nxt_st.imm_hold && !nxt_st.data_hold);
		nxt_st.rdy = rdy_now;
		nxt_st.nrfd = !rdy_now;
		nxt_st.dma_req = dma_input_enable & nxt_st.data_in;
		nxt_st.irq = data_in_irq_enable & nxt_st.data_in;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Ready idles true so the bus is not held off straight out of reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_ff <= '0;
			st_ff.rdy <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from the state flops
	// ----------------------------------------
	always_comb begin
		rx_data = st_ff.rx_byte;
		data_in_flag = st_ff.data_in;
		data_in_irq = st_ff.irq;
		end_rx_flag = st_ff.end_rx;
		eoi_seen = st_ff.eoi_seen;
		newline_hit_flag = st_ff.nl_hit;
		match_char_hit_flag = st_ff.match_hit;
		irq_status_1 = 8'h00;
		irq_status_1[`LAH_END_RX_BIT] = st_ff.end_rx;
		acceptor_status_reg = 8'h00;
		acceptor_status_reg[`LAH_ANHS_BIT] = st_ff.imm_hold;
		acceptor_status_reg[`LAH_ACCEPT_HOLD_STATE_BIT] = st_ff.accept_hold_state;
		nrfd_assert = st_ff.nrfd;
		dac_holdoff = st_ff.accept_hold_state;
		ready_for_next = st_ff.rdy;
		monitor_mode_active = st_ff.cont_forced;
		dma_request_pin = st_ff.dma_req;
	end
endmodule

/* File: verilog/lah_cfg.svh */
// Constants for the listener acceptor holdoff block.
// Assumes inclusion by bare name from design and verification files.
`ifndef LAH_CFG_SVH
`define LAH_CFG_SVH
// ----------------------------------------
// Receive mode codes, newline character and status positions
// ----------------------------------------
`define LAH_MODE_NORMAL 2'h0
`define LAH_MODE_HOLD_ALL 2'h1
`define LAH_MODE_HOLD_END 2'h2
`define LAH_MODE_CONT 2'h3
`define LAH_NEWLINE 8'h0a
`define LAH_END_RX_BIT 4
`define LAH_ANHS_BIT 4
`define LAH_ACCEPT_HOLD_STATE_BIT 3
// ----------------------------------------
// Auxiliary command codes (host side)
// ----------------------------------------
`define LAH_AUX_NONE 3'h0
`define LAH_AUX_HLDI 3'h1
`define LAH_AUX_RHDF 3'h2
`define LAH_AUX_VALID 3'h3
`define LAH_AUX_NONVALID 3'h4
`define LAH_AUX_LTN 3'h5
`define LAH_AUX_LTN_CONT 3'h6
`define LAH_AUX_CHIP_RESET 3'h7
// ----------------------------------------
// Command byte classes
// ----------------------------------------
`define LAH_CMD_GET 7'h08
`define LAH_CMD_SDC 7'h04
`define LAH_CMD_DCL 7'h14
`define LAH_CMD_UNL 7'h3f
`define LAH_CMD_UNT 7'h5f
`endif

/* File: verilog/lah_pkg.sv */
// Types for the listener acceptor holdoff block.
// Assumes lah_cfg.svh holds the numeric constants.
package lah_pkg;
	typedef enum logic [1:0] {
		LAH_NORMAL,
		LAH_HOLD_ALL,
		LAH_HOLD_END,
		LAH_CONT
	} lah_mode_t;
	typedef logic [2:0] lah_aux_t;
endpackage

/* File: verilog/lah_cmd_decode.sv */
// Command byte decoder: selects which command bytes raise a DAC holdoff.
// Assumes the byte and the addressing state are stable for the cycle.
`timescale 1ns/1ps
`include "lah_cfg.svh"
module lah_cmd_decode (
	// Command byte and addressing
	input wire logic [7:0] cmd_byte,
	input wire logic talker_addressed,
	input wire logic listener_addressed,
	input wire logic talker_primary_seen,
	input wire logic listener_primary_seen,
	input wire logic dual_ext_addr,
	input wire logic cmd_undefined,
	// Hold selections
	input wire logic passthrough_enable,
	input wire logic secondary_passthrough_opt,
	input wire logic hold_on_trigger_cmd,
	input wire logic hold_on_trigger_state,
	input wire logic hold_on_clear_cmd,
	input wire logic hold_on_clear_state,
	input wire logic hold_on_talk_group,
	input wire logic hold_on_listen_group,
	input wire logic hold_on_unaddress,
	input wire logic hold_every_command,
	// Result
	output logic select_hold_signal
);
	logic [6:0] c;
	logic ucg;
	logic acg;
	logic lag;
	logic tag;
	logic scg;
	logic is_get;
	logic is_sdc;
	logic is_dcl;
	logic is_unl;
	logic is_unt;

	// Group classes from the top bits of the seven-bit command
	always_comb begin
		c = cmd_byte[6:0];
		acg = (c[6:4] == 3'h0);
		ucg = (c[6:4] == 3'h1);
		lag = (c[6:5] == 2'h1);
		tag = (c[6:5] == 2'h2);
		scg = (c[6:5] == 2'h3);
		is_get = (c == `LAH_CMD_GET);
		is_sdc = (c == `LAH_CMD_SDC);
		is_dcl = (c == `LAH_CMD_DCL);
		is_unl = (c == `LAH_CMD_UNL);
		is_unt = (c == `LAH_CMD_UNT);
	end

	// Sum of all enabled holdoff cases
	assign select_hold_signal =
		((ucg | (acg & (talker_addressed | listener_addressed))) & cmd_undefined & passthrough_enable)
		| (secondary_passthrough_opt & scg & passthrough_enable)
		| (hold_on_trigger_cmd & is_get)
		| (hold_on_clear_cmd & (is_sdc | is_dcl))
		| (hold_on_talk_group & tag & ~is_unt)
		| (hold_on_listen_group & lag & ~is_unl)
		| (hold_on_unaddress & (is_unt | is_unl))
		| (hold_every_command & (ucg | acg | scg))
		| (hold_on_clear_state & (is_dcl | (is_sdc & listener_addressed)))
		| (hold_on_trigger_state & is_get & listener_addressed)
		| (scg & (talker_primary_seen | listener_primary_seen) & dual_ext_addr);
endmodule

/* File: verilog/lah_end_detect.sv */
// End detector: classifies a received byte against EOI, newline and match char.
// Assumes the byte and EOI are sampled together with the handshake.
`timescale 1ns/1ps
`include "lah_cfg.svh"
module lah_end_detect (
	// Byte and terminator settings
	input wire logic [7:0] rx_byte,
	input wire logic rx_eoi,
	input wire logic [7:0] match_char_reg,
	input wire logic match_end_enable,
	input wire logic newline_end_enable,
	input wire logic newline_term_enable,
	// Classification
	output logic newline_hit,
	output logic match_hit,
	output logic end_hit,
	output logic end_cond
);
	// Report flags follow the enables; hold condition uses its own newline enable
	always_comb begin
		newline_hit = newline_end_enable & (rx_byte == `LAH_NEWLINE);
		match_hit = match_end_enable & (rx_byte == match_char_reg);
		end_hit = rx_eoi | newline_hit | match_hit;
		end_cond = rx_eoi | match_hit | (newline_term_enable & (rx_byte == `LAH_NEWLINE));
	end
endmodule

/* File: verif/lah_props.sv */
// Checker of port relations of the listener holdoff block.
// Assumes it is bound to lah_listener_holdoff and shares its clock.
`timescale 1ns/1ps
`include "lah_cfg.svh"
module lah_props (
	// Clock, reset and inputs
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic byte_accepted,
	input wire logic [7:0] bus_data,
	input wire logic bus_eoi,
	input wire logic bus_atn,
	input wire logic listener_addressed,
	input wire lah_pkg::lah_aux_t aux_cmd,
	input wire logic aux_cmd_strobe,
	input wire logic [1:0] aux_mode_reg_a,
	// Outputs watched
	input wire logic dma_request_pin,
	input wire logic [7:0] rx_data,
	input wire logic data_in_flag,
	input wire logic end_rx_flag,
	input wire logic eoi_seen,
	input wire logic [7:0] irq_status_1,
	input wire logic [7:0] acceptor_status_reg,
	input wire logic nrfd_assert,
	input wire logic dac_holdoff,
	input wire logic ready_for_next,
	input wire logic monitor_mode_active
);
	import lah_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic dat;
	logic rel;
	// Accepted data byte and release commands, aux strobes excluded to keep chip reset apart
	assign dat = byte_accepted && !bus_atn && listener_addressed && !aux_cmd_strobe;
	assign rel = aux_cmd_strobe && (aux_cmd == `LAH_AUX_VALID || aux_cmd == `LAH_AUX_NONVALID);
	AST_ATN_RDY: assert property (bus_atn && !aux_cmd_strobe |=> ready_for_next)
		else $error("ready low after ATN");
	AST_NRFD: assert property (nrfd_assert == !ready_for_next)
		else $error("NRFD does not follow ready");
	AST_STORE: assert property (dat && !monitor_mode_active && aux_mode_reg_a != `LAH_MODE_CONT
		|=> data_in_flag && rx_data == $past(bus_data)) else $error("byte not stored");
	AST_EOI: assert property (dat && bus_eoi |=> end_rx_flag && eoi_seen && irq_status_1[`LAH_END_RX_BIT])
		else $error("EOI byte not reported");
	AST_NO_DAC: assert property (byte_accepted && !bus_atn && !dac_holdoff |=> !dac_holdoff)
		else $error("DAC hold on data byte");
	AST_VALID: assert property (rel && !(byte_accepted && bus_atn)
		|=> !dac_holdoff && !acceptor_status_reg[`LAH_ACCEPT_HOLD_STATE_BIT]) else $error("DAC hold not released");
	AST_SASR3: assert property (acceptor_status_reg[`LAH_ACCEPT_HOLD_STATE_BIT] == dac_holdoff)
		else $error("hold status bit differs");
	AST_HLDI: assert property (aux_cmd_strobe && aux_cmd == `LAH_AUX_HLDI |=> acceptor_status_reg[`LAH_ANHS_BIT])
		else $error("immediate hold not shown");
	AST_HLDI_KEEP: assert property (acceptor_status_reg[`LAH_ANHS_BIT] && !aux_cmd_strobe
		|=> acceptor_status_reg[`LAH_ANHS_BIT]) else $error("immediate hold dropped");
	AST_DMA: assert property (dma_request_pin |-> data_in_flag)
		else $error("DMA request without byte");
endmodule
bind lah_listener_holdoff lah_props u_props (.ref_clk, .reset, .byte_accepted, .bus_data, .bus_eoi, .bus_atn,
	.listener_addressed, .aux_cmd, .aux_cmd_strobe, .aux_mode_reg_a, .dma_request_pin, .rx_data, .data_in_flag,
	.end_rx_flag, .eoi_seen, .irq_status_1, .acceptor_status_reg, .nrfd_assert, .dac_holdoff, .ready_for_next,
	.monitor_mode_active);

/* File: verif/lah_peer.sv */
// Far-side talker and controller model that hands bytes over the handshake.
// Assumes calls start just after a clock edge; returns once the answer is out.
`timescale 1ns/1ps
module lah_peer (
	// Clock and acceptor state
	input wire logic ref_clk,
	input wire logic ready_for_next,
	input wire logic dac_holdoff,
	// Byte on the bus
	output logic byte_accepted,
	output logic [7:0] bus_data,
	output logic bus_eoi,
	output logic bus_atn
);
	// Idle bus at time zero
	initial begin
		byte_accepted = 1'b0;
		bus_data = 8'h00;
		bus_eoi = 1'b0;
		bus_atn = 1'b0;
	end
	// A talker waits for NRFD and DAC release, a controller for DAC release only; bounded so a stuck hold shows
	task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
		int i;
		i = 0;
		while (i < 300 && (dac_holdoff || !(atn || ready_for_next))) begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		bus_data = b;
		bus_eoi = eoi;
		bus_atn = atn;
		byte_accepted = 1'b1;
		@(posedge ref_clk);
		#1;
		// Released lines must not show the old byte
		byte_accepted = 1'b0;
		bus_data = ~b;
		bus_eoi = 1'b0;
		bus_atn = 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench of the listener holdoff block.
// Assumes the peer model drives the bus byte and the bench the host side.
`timescale 1ns/1ps
`include "lah_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	import lah_pkg::*;
	logic ref_clk, reset, byte_accepted, bus_eoi, bus_atn, listener_addressed, aux_cmd_strobe, rx_read_strobe;
	logic match_end_enable, newline_end_enable, newline_term_enable, data_in_irq_enable, dma_input_enable, dma_ack_pin;
	logic [7:0] bus_data, match_char_reg, rx_data, irq_status_1, acceptor_status_reg, b, r, e;
	logic [1:0] aux_mode_reg_a;
	logic [11:0] h;
	logic [20:0] tbl [15];
	lah_aux_t aux_cmd;
	logic dma_request_pin, data_in_flag, data_in_irq, end_rx_flag, eoi_seen, newline_hit_flag, match_char_hit_flag;
	logic nrfd_assert, dac_holdoff, ready_for_next, monitor_mode_active, seen, x;
	logic [7:0] exp_q [$];
	int n_errors, n_checks, seed, i;
	lah_peer peer (.ref_clk, .ready_for_next, .dac_holdoff, .byte_accepted, .bus_data, .bus_eoi, .bus_atn);
	lah_listener_holdoff dut (.ref_clk, .reset, .byte_accepted, .bus_data, .bus_eoi, .bus_atn, .listener_addressed,
		.talker_addressed(1'b0), .talker_primary_seen(1'b0), .listener_primary_seen(h[9]), .cmd_undefined(h[8]),
		.aux_cmd, .aux_cmd_strobe, .rx_read_strobe, .aux_mode_reg_a, .match_char_reg, .match_end_enable,
		.newline_end_enable, .newline_term_enable, .data_in_irq_enable, .dma_input_enable, .dual_ext_addr(h[10]),
		.passthrough_enable(h[8]), .secondary_passthrough_opt(h[11]), .hold_on_trigger_cmd(h[7]),
		.hold_on_trigger_state(h[6]), .hold_on_clear_cmd(h[5]), .hold_on_clear_state(h[4]), .hold_on_talk_group(h[3]),
		.hold_on_listen_group(h[2]), .hold_on_unaddress(h[1]), .hold_every_command(h[0]), .dma_ack_pin,
		.dma_request_pin, .rx_data, .data_in_flag, .data_in_irq, .end_rx_flag, .eoi_seen, .newline_hit_flag,
		.match_char_hit_flag, .irq_status_1, .acceptor_status_reg, .nrfd_assert, .dac_holdoff, .ready_for_next,
		.monitor_mode_active);
	// ----
	// Tasks
	// ----
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic aux(input lah_aux_t c);
		aux_cmd = c;
		aux_cmd_strobe = 1'b1;
		tick();
		aux_cmd_strobe = 1'b0;
		tick();
	endtask
	// Host read, or DMA acknowledge standing in for it
	task automatic rd(input logic dma);
		dma_ack_pin = dma;
		rx_read_strobe = !dma;
		tick();
		dma_ack_pin = 1'b0;
		rx_read_strobe = 1'b0;
		tick();
	endtask
	task automatic dat(input logic [7:0] v, input logic eoi, input logic keep);
		if (keep) exp_q.push_back(v);
		peer.send(v, 1'b0, eoi);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Result watcher: each fresh data-in flag takes the oldest note
	always @(posedge ref_clk) begin
		if (data_in_flag === 1'b1 && !seen) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : 8'h00;
			`CHK(rx_data, e)
		end
		seen <= (data_in_flag === 1'b1);
	end
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Watchdog well beyond the roughly 140 cycles of the run
	initial begin
		#40000;
		n_errors++;
		stop_test();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		{reset, listener_addressed, aux_cmd_strobe, rx_read_strobe, dma_ack_pin} = 5'h10;
		{match_end_enable, newline_end_enable, newline_term_enable} = 3'h0;
		{data_in_irq_enable, dma_input_enable, aux_cmd, aux_mode_reg_a, h} = '0;
		match_char_reg = 8'h00;
		seed = 97;
		// Last three rows: secondary pass-through, dual extended addressing with and without a primary
		tbl = '{{1'b1, 8'h08, 12'h080}, {1'b1, 8'h08, 12'h040}, {1'b1, 8'h04, 12'h020}, {1'b1, 8'h14, 12'h010},
			{1'b1, 8'h41, 12'h008}, {1'b1, 8'h21, 12'h004}, {1'b0, 8'h3f, 12'h004}, {1'b1, 8'h3f, 12'h002},
			{1'b1, 8'h5f, 12'h002}, {1'b1, 8'h01, 12'h001}, {1'b1, 8'h61, 12'h001}, {1'b1, 8'h15, 12'h100},
			{1'b1, 8'h62, 12'h900}, {1'b1, 8'h63, 12'h600}, {1'b0, 8'h63, 12'h400}};
		repeat (2) tick();
		reset = 1'b0;
		listener_addressed = 1'b1;
		{data_in_irq_enable, dma_input_enable} = 2'h3;
		// Normal mode: holdoff until read, host and DMA reads alternate
		for (i = 0; i < 4; i++) begin
			dat(8'($random(seed)), 1'b0, 1'b1);
			`CHK(nrfd_assert, 1'b1)
			`CHK(dma_request_pin, 1'b1)
			`CHK(data_in_irq, 1'b1)
			rd(i[0]);
			`CHK(ready_for_next, 1'b1)
		end
		// Hold-all: a read leaves the holdoff, only release clears it
		aux_mode_reg_a = `LAH_MODE_HOLD_ALL;
		dat(8'($random(seed)), 1'b0, 1'b1);
		rd(1'b0);
		`CHK(nrfd_assert, 1'b1)
		aux(`LAH_AUX_RHDF);
		`CHK(ready_for_next, 1'b1)
		// Hold-END over each END cause: none, EOI, match char, newline
		aux_mode_reg_a = `LAH_MODE_HOLD_END;
		match_char_reg = 8'($random(seed)) | 8'h80;
		for (i = 0; i < 4; i++) begin
			r = 8'($random(seed));
			match_end_enable = (i == 2);
			newline_end_enable = (i == 3);
			newline_term_enable = (i == 3);
			b = (i == 2) ? match_char_reg : (i == 3) ? `LAH_NEWLINE : {2'b01, r[5:0]};
			dat(b, i == 1, 1'b1);
			`CHK(end_rx_flag, i != 0)
			`CHK(match_char_hit_flag, i == 2)
			`CHK(newline_hit_flag, i == 3)
			`CHK(eoi_seen, i == 1)
			rd(1'b0);
			`CHK(ready_for_next, i == 0)
			if (i != 0) aux(`LAH_AUX_RHDF);
		end
		{match_end_enable, newline_end_enable, newline_term_enable} = 3'h0;
		// Monitor by mode field: no store, hold only on END
		aux_mode_reg_a = `LAH_MODE_CONT;
		for (i = 0; i < 2; i++) begin
			dat(8'($random(seed)), i[0], 1'b0);
			`CHK(data_in_flag, 1'b0)
			`CHK(ready_for_next, !i[0])
		end
		aux(`LAH_AUX_RHDF);
		// Forced monitor, ended by plain listen and then by unaddressing
		aux_mode_reg_a = `LAH_MODE_NORMAL;
		aux(`LAH_AUX_LTN_CONT);
		`CHK(monitor_mode_active, 1'b1)
		dat(8'($random(seed)), 1'b0, 1'b0);
		`CHK(data_in_flag, 1'b0)
		aux(`LAH_AUX_LTN);
		`CHK(monitor_mode_active, 1'b0)
		aux(`LAH_AUX_LTN_CONT);
		listener_addressed = 1'b0;
		dat(8'($random(seed)), 1'b0, 1'b0);
		`CHK(monitor_mode_active, 1'b0)
		`CHK(data_in_flag, 1'b0)
		listener_addressed = 1'b1;
		// Immediate holdoff: ATN overrides, release and chip reset clear
		aux(`LAH_AUX_HLDI);
		`CHK(acceptor_status_reg[`LAH_ANHS_BIT], 1'b1)
		`CHK(ready_for_next, 1'b0)
		// Ready is looked at while ATN still stands; once ATN drops the holdoff shows again
		fork
			peer.send({1'b0, `LAH_CMD_UNL}, 1'b1, 1'b0);
			begin
				tick();
				`CHK(ready_for_next, 1'b1)
			end
		join
		`CHK(ready_for_next, 1'b0)
		aux(`LAH_AUX_RHDF);
		`CHK(acceptor_status_reg[`LAH_ANHS_BIT], 1'b0)
		aux(`LAH_AUX_HLDI);
		aux(`LAH_AUX_CHIP_RESET);
		tick();
		`CHK(acceptor_status_reg[`LAH_ANHS_BIT], 1'b0)
		// DAC holdoff classes, released by valid and nonvalid in turn
		for (i = 0; i < 15; i++) begin
			{x, b, h} = tbl[i];
			peer.send(b, 1'b1, 1'b0);
			`CHK(dac_holdoff, x)
			`CHK(acceptor_status_reg[`LAH_ACCEPT_HOLD_STATE_BIT], x)
			aux(i[0] ? `LAH_AUX_VALID : `LAH_AUX_NONVALID);
			`CHK(dac_holdoff, 1'b0)
		end
		// A data byte never takes a DAC holdoff
		h = 12'h001;
		dat(8'($random(seed)), 1'b0, 1'b1);
		`CHK(dac_holdoff, 1'b0)
		rd(1'b0);
		tick();
		`CHK(exp_q.size(), 0)
		stop_test();
	end
endmodule
